// file: src/ppsc_pkg.sv
// Constants and types for the port pin state control block.
// Assumes a single system clock and that system state is decoded upstream.
//
// Functional notes
// [R1] Hold: inputs float, outputs keep last level
// [R2] Reset output low only on watchdog reset
// [R3] Modes 1-4 upper address: L/T/T/address
// [R4] Mode 5 port 5 follows direction bits; code floats every pin in standby
// [R5] Strobes high in reset, float otherwise idle
// [R6] Bus request floats in standby if released
// [R7] Bus acknowledge high in standby if enabled
// [R8] Bus acknowledge general I/O or low-released
// [R9] Refresh strobe toggles in standby when enabled
// [R10] Refresh strobe high while released when enabled
// [R11] Refresh pin refresh output or general I/O
// [R12] Upper chip selects high/float standby, hold released
// [R13] Chip select zero low/float standby, hold released
// [R14] Chip select zero output or input; reset low
// [R15] Port A 6..4 address or I/O by enable
// [R16] Port A 7..4 standby follows direction bits
// [R17] Port A 7..4 release follows timer and direction
// [R18] Port 7 low pins input only always
// [R19] Hardware standby floats every controlled pin
package ppsc_pkg;

  // System states, decoded by the system controller
  typedef enum logic [2:0] {
    PPSC_ST_RESET = 3'h0,
    PPSC_ST_HWSTBY = 3'h1,
    PPSC_ST_SWSTBY = 3'h2,
    PPSC_ST_BUSREL = 3'h3,
    PPSC_ST_RUN    = 3'h4
  } ppsc_state_t;

  // Operating mode width and mode codes
  localparam int unsigned PPSC_MODE_W = 3;
  localparam logic [2:0] PPSC_MODE_5 = 3'h5;
  localparam logic [2:0] PPSC_MODE_3 = 3'h3;
  localparam logic [2:0] PPSC_MODE_4 = 3'h4;

  // Pin group widths
  localparam int unsigned PPSC_P5_W  = 4;
  localparam int unsigned PPSC_CSU_W = 3;
  localparam int unsigned PPSC_PA_W  = 4;
  localparam int unsigned PPSC_P7_W  = 6;
  localparam int unsigned PPSC_STB_W = 4;

  // Reset value of all held output levels
  localparam logic PPSC_HOLD_RST = 1'b0;

endpackage

// file: src/ppsc_top.sv
// Pin driver/enable decision for ports 5 to 8 and port A upper pins.
// Assumes system state, mode and enables are synchronous to clk.
`timescale 1ns/1ps
module ppsc_top
  import ppsc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire ppsc_state_t            sys_state,        // Current system state
  input  wire logic [PPSC_MODE_W-1:0] op_mode,          // Operating mode 1..7
  input  wire logic                   watchdog_reset,   // Reset caused by watchdog_counter
  input  wire logic                   bus_release_enable,
  input  wire logic                   refresh_strobe_enable,
  input  wire logic [2:0]             upper_address_enable, // Bits for PA6..PA4
  input  wire logic [PPSC_P5_W-1:0]   p5_ddr,
  input  wire logic [PPSC_P5_W-1:0]   p5_gpio_out,
  input  wire logic [PPSC_P5_W-1:0]   addr_hi,          // Address bits 19..16
  input  wire logic [PPSC_STB_W-1:0]  strobe_val,       // Address, read, high, low write
  input  wire logic                   p61_ddr,
  input  wire logic                   p61_gpio_out,
  input  wire logic                   p62_ddr,
  input  wire logic                   p62_gpio_out,
  input  wire logic                   bus_ack_val,      // Acknowledge level from controller
  input  wire logic                   p80_ddr,
  input  wire logic                   p80_gpio_out,
  input  wire logic                   refresh_strobe_val,
  input  wire logic [PPSC_CSU_W-1:0]  csu_ddr,
  input  wire logic [PPSC_CSU_W-1:0]  chip_select_upper_val,
  input  wire logic                   cs_zero_ddr,
  input  wire logic                   chip_select_zero_val,
  input  wire logic [PPSC_PA_W-1:0]   pa_ddr,           // PA7..PA4
  input  wire logic [PPSC_PA_W-1:0]   pa_gpio_out,
  input  wire logic [PPSC_PA_W-1:0]   pa_timer_oe,      // timer_unit output enables
  input  wire logic [PPSC_PA_W-1:0]   pa_timer_val,
  input  wire logic [PPSC_PA_W-1:0]   addr_top,         // Address bits 23..20
  output logic      [PPSC_P5_W-1:0]   p5_o,
  output logic      [PPSC_P5_W-1:0]   p5_oe,
  output logic      [PPSC_STB_W-1:0]  strobe_o,
  output logic      [PPSC_STB_W-1:0]  strobe_oe,
  output logic                        p61_oe,
  output logic                        p61_o,
  output logic                        p62_o,
  output logic                        p62_oe,
  output logic                        p80_o,
  output logic                        p80_oe,
  output logic      [PPSC_CSU_W-1:0]  csu_o,
  output logic      [PPSC_CSU_W-1:0]  csu_oe,
  output logic                        cs_zero_o,
  output logic                        cs_zero_oe,
  output logic      [PPSC_PA_W-1:0]   pa_o,
  output logic      [PPSC_PA_W-1:0]   pa_oe,
  output logic      [PPSC_P7_W-1:0]   p7_oe,
  output logic                        reset_output_o,
  output logic                        reset_output_oe
);

  // State decode
  logic st_rst, st_hw, st_sw, st_rel; // Decoded system state flags
  logic ext_bus;  // Modes 1 to 5
  logic m14;      // Modes 1 to 4
  logic m5;
  logic m34;
  assign st_rst  = (sys_state == PPSC_ST_RESET);
  assign st_hw   = (sys_state == PPSC_ST_HWSTBY);
  assign st_sw   = (sys_state == PPSC_ST_SWSTBY);
  assign st_rel  = (sys_state == PPSC_ST_BUSREL);
  assign m5      = (op_mode == PPSC_MODE_5);
  assign m34     = (op_mode == PPSC_MODE_3) || (op_mode == PPSC_MODE_4);
  assign m14     = (op_mode != 3'h0) && (op_mode < PPSC_MODE_5);
  assign ext_bus = m14 || m5;

  // Combinational next pin levels and enables
  logic [PPSC_P5_W-1:0]  p5_d, p5_oe_d;
  logic [PPSC_STB_W-1:0] stb_d, stb_oe_d;
  logic                  p61_d, p61_oe_d, p62_d, p62_oe_d, p80_d, p80_oe_d;
  logic [PPSC_CSU_W-1:0] csu_d, csu_oe_d;
  logic                  cs_zero_d, cs_zero_oe_d;
  logic [PPSC_PA_W-1:0]  pa_d, pa_oe_d;
  logic                  rst_out_d, rst_out_oe_d;

  // Port 5 address pins, one per bit
  genvar gi;
  generate
    for (gi = 0; gi < PPSC_P5_W; gi++)
    begin : g_p5
      always_comb
      begin
        // Hold default: keep level, float inputs
        p5_d[gi]    = p5_o[gi];
        p5_oe_d[gi] = p5_oe[gi] & p5_ddr[gi]; // see [R1]
        if (st_hw)
        begin
          p5_oe_d[gi] = 1'b0; // see [R19]
        end
        else if (m14)
        begin
          p5_d[gi]    = st_rst ? 1'b0 : addr_hi[gi]; // see [R3]
          p5_oe_d[gi] = st_rst || (sys_state == PPSC_ST_RUN);
        end
        else if (m5)
        begin
          if (st_rst || st_rel || (st_sw && p5_ddr[gi])) // see [R4]
            p5_oe_d[gi] = 1'b0;
          else if (sys_state == PPSC_ST_RUN)
          begin
            p5_d[gi]    = addr_hi[gi];
            p5_oe_d[gi] = p5_ddr[gi];
          end
        end
        else if (st_rst)
          p5_oe_d[gi] = 1'b0;
        else if (sys_state == PPSC_ST_RUN)
        begin
          p5_d[gi]    = p5_gpio_out[gi];
          p5_oe_d[gi] = p5_ddr[gi];
        end
      end
    end
  endgenerate

  // Strobes, bus request, bus acknowledge, refresh pin
  always_comb
  begin
    stb_d    = strobe_o;
    stb_oe_d = strobe_oe;
    p61_d    = p61_o;
    p61_oe_d = p61_oe & p61_ddr;
    p62_d    = p62_o;
    p62_oe_d = p62_oe & p62_ddr;
    p80_d    = p80_o;
    p80_oe_d = p80_oe & p80_ddr;
    if (st_hw || st_rst)
    begin
      stb_oe_d = {PPSC_STB_W{1'b0}}; // see [R19]
      p61_oe_d = 1'b0;
      p62_oe_d = 1'b0;
      p80_oe_d = 1'b0;
      if (st_rst && ext_bus)
      begin
        stb_d    = {PPSC_STB_W{1'b1}}; // see [R5]
        stb_oe_d = {PPSC_STB_W{1'b1}};
      end
    end
    else if (ext_bus)
    begin
      if (st_sw || st_rel)
        stb_oe_d = {PPSC_STB_W{1'b0}}; // see [R5]
      else
      begin
        stb_d    = strobe_val;
        stb_oe_d = {PPSC_STB_W{1'b1}};
      end
      // Bus request is input-side; floats in release or enabled standby
      if (st_rel || (st_sw && bus_release_enable))
        p61_oe_d = 1'b0; // see [R6]
      else if (!st_sw)
      begin
        p61_d    = p61_gpio_out;
        p61_oe_d = p61_ddr & ~bus_release_enable;
      end
      // Bus acknowledge
      if (st_rel)
      begin
        p62_d    = 1'b0; // see [R8]
        p62_oe_d = 1'b1;
      end
      else if (st_sw && bus_release_enable)
      begin
        p62_d    = 1'b1; // see [R7]
        p62_oe_d = 1'b1;
      end
      else if (!st_sw)
      begin
        p62_d    = bus_release_enable ? bus_ack_val : p62_gpio_out; // see [R8]
        p62_oe_d = bus_release_enable | p62_ddr;
      end
      // Refresh strobe
      if (refresh_strobe_enable && st_sw)
      begin
        p80_d    = refresh_strobe_val; // see [R9]
        p80_oe_d = 1'b1;
      end
      else if (refresh_strobe_enable && st_rel)
      begin
        p80_d    = 1'b1; // see [R10]
        p80_oe_d = 1'b1;
      end
      else if (!st_sw && !st_rel)
      begin
        p80_d    = refresh_strobe_enable ? refresh_strobe_val : p80_gpio_out; // see [R11]
        p80_oe_d = refresh_strobe_enable | p80_ddr;
      end
    end
    else if (!st_sw && !st_rel)
    begin
      // Single-chip modes: plain I/O while running
      stb_oe_d = {PPSC_STB_W{1'b0}};
      p61_d    = p61_gpio_out;
      p61_oe_d = p61_ddr;
      p62_d    = p62_gpio_out;
      p62_oe_d = p62_ddr;
      p80_d    = p80_gpio_out;
      p80_oe_d = p80_ddr;
    end
  end

  // Chip selects
  always_comb
  begin
    csu_d    = csu_o;
    csu_oe_d = csu_oe & csu_ddr; // see [R12]
    cs_zero_d    = cs_zero_o;
    cs_zero_oe_d = cs_zero_oe & cs_zero_ddr; // see [R13]
    if (st_hw || (st_rst && !m14))
    begin
      csu_oe_d = {PPSC_CSU_W{1'b0}}; // see [R19]
      cs_zero_oe_d = 1'b0;
    end
    else if (st_rst)
    begin
      csu_oe_d = {PPSC_CSU_W{1'b0}};
      cs_zero_d    = 1'b0; // see [R14]
      cs_zero_oe_d = 1'b1;
    end
    else if (st_sw)
    begin
      if (m14)
      begin
        csu_d    = {PPSC_CSU_W{1'b1}}; // see [R12]
        csu_oe_d = csu_ddr;
      end
      if (ext_bus)
      begin
        cs_zero_d    = 1'b0; // see [R13]
        cs_zero_oe_d = cs_zero_ddr;
      end
    end
    else if (!st_rel)
    begin
      csu_d    = chip_select_upper_val;
      csu_oe_d = csu_ddr;
      cs_zero_d    = chip_select_zero_val; // see [R14]
      cs_zero_oe_d = cs_zero_ddr;
    end
  end

  // Port A upper pins: index 3 is PA7, 2..0 are PA6..PA4
  always_comb
  begin
    pa_d    = pa_o;
    pa_oe_d = pa_oe & pa_ddr;
    if (st_hw || st_rst)
      pa_oe_d = {PPSC_PA_W{1'b0}}; // see [R19]
    else if (m34 && st_sw)
    begin
      pa_d    = pa_gpio_out; // see [R16]
      pa_oe_d = pa_ddr;
    end
    else if (m34 && st_rel)
    begin
      pa_d    = (pa_timer_oe & pa_timer_val) | (~pa_timer_oe & pa_gpio_out); // see [R17]
      pa_oe_d = pa_timer_oe | pa_ddr;
    end
    else if (m34 && !st_sw && !st_rel)
    begin
      pa_d[3]    = addr_top[3];
      pa_oe_d[3] = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
        pa_d[i]    = upper_address_enable[i] ? pa_gpio_out[i] : addr_top[i]; // see [R15]
        pa_oe_d[i] = upper_address_enable[i] ? pa_ddr[i] : 1'b1;
      end
    end
    else if (!st_sw && !st_rel)
    begin
      pa_d    = pa_gpio_out;
      pa_oe_d = pa_ddr;
    end
  end

  // Reset output only ever pulls low, and only for a watchdog reset
  assign rst_out_d    = 1'b0;
  assign rst_out_oe_d = st_rst && watchdog_reset; // see [R2]

  // Registered pin drivers; reset floats everything
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      p5_o <= {PPSC_P5_W{PPSC_HOLD_RST}};
      p5_oe <= '0;
      strobe_o <= {PPSC_STB_W{PPSC_HOLD_RST}};
      strobe_oe <= '0;
      p61_o <= PPSC_HOLD_RST;
      p61_oe <= 1'b0;
      p62_o <= PPSC_HOLD_RST;
      p62_oe <= 1'b0;
      p80_o <= PPSC_HOLD_RST;
      p80_oe <= 1'b0;
      csu_o <= {PPSC_CSU_W{PPSC_HOLD_RST}};
      csu_oe <= '0;
      cs_zero_o <= PPSC_HOLD_RST;
      cs_zero_oe <= 1'b0;
      pa_o <= {PPSC_PA_W{PPSC_HOLD_RST}};
      pa_oe <= '0;
      reset_output_o <= 1'b0;
      reset_output_oe <= 1'b0;
    end
    else
    begin
      p5_o <= p5_d;
      p5_oe <= p5_oe_d;
      strobe_o <= stb_d;
      strobe_oe <= stb_oe_d;
      p61_o <= p61_d;
      p61_oe <= p61_oe_d;
      p62_o <= p62_d;
      p62_oe <= p62_oe_d;
      p80_o <= p80_d;
      p80_oe <= p80_oe_d;
      csu_o <= csu_d;
      csu_oe <= csu_oe_d;
      cs_zero_o <= cs_zero_d;
      cs_zero_oe <= cs_zero_oe_d;
      pa_o <= pa_d;
      pa_oe <= pa_oe_d;
      reset_output_o <= rst_out_d;
      reset_output_oe <= rst_out_oe_d;
    end
  end

  // Port 7 low pins never drive
  assign p7_oe = {PPSC_P7_W{1'b0}}; // see [R18]

  // Checks
  sequence hw_seen;
    sys_state == PPSC_ST_HWSTBY;
  endsequence

  hw_float_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R19]
    hw_seen |=> (p5_oe == '0) && (strobe_oe == '0) && !cs_zero_oe && (pa_oe == '0))
    else $error("pins driven in hardware standby");
  rst_out_wdog_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R2]
    reset_output_oe |-> $past(watchdog_reset) && !reset_output_o)
    else $error("reset output driven without watchdog");
  addr_rst_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R3]
    (st_rst && m14) |=> (p5_oe == '1) && (p5_o == '0))
    else $error("address pins not low in reset");
  strobe_rst_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R5]
    (st_rst && ext_bus) |=> (strobe_oe == '1) && (strobe_o == '1))
    else $error("strobes not high in reset");
  back_rel_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R8]
    (st_rel && ext_bus) |=> p62_oe && !p62_o)
    else $error("bus acknowledge not low when released");
  refresh_rel_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R10]
    (st_rel && ext_bus && refresh_strobe_enable) |=> p80_oe && p80_o)
    else $error("refresh pin not high when released");
  cs_zero_sw_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R13]
    (st_sw && ext_bus) |=> (cs_zero_oe == $past(cs_zero_ddr)) && (!cs_zero_oe || !cs_zero_o))
    else $error("chip select zero wrong in standby");
  bus_req_sw_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R6]
    (st_sw && ext_bus && bus_release_enable) |=> !p61_oe)
    else $error("bus request driven in standby");
  csu_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // see [R12]
    (st_rel && m14 && $past(st_rel)) |=> $stable(csu_o))
    else $error("upper chip selects changed in release");

endmodule

// file: tb/ppsc_ext_bus.sv
// Far-side model: external memory strobe inputs seen through the pins.
// Assumes the design's strobe level and enable outputs; no pull resistors.
`timescale 1ns/1ps
module ppsc_ext_bus
(
  input  wire logic       clk,
  input  wire logic [3:0] strobe_o,
  input  wire logic [3:0] strobe_oe,
  output logic      [3:0] strobe_lvl
);
  // Last level driven onto each strobe line
  logic [3:0] last_q = 4'h0;

  // Remember the level last driven; a floating line does not update it
  always_ff @(posedge clk)
  begin
    last_q <= (strobe_oe & strobe_o) | (~strobe_oe & last_q);
  end

  // A floating line shows the inverse of the last driven level, so a float is visible
  assign strobe_lvl = (strobe_oe & strobe_o) | (~strobe_oe & ~last_q);
endmodule

// file: tb/port_pin_state_control_tb.sv
// Self-checking bench for the port pin state control block.
// Assumes outputs are registered one cycle after the inputs.
`timescale 1ns/1ps
module port_pin_state_control_tb;
  import ppsc_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0;     // Clock and async reset
  ppsc_state_t sys_state = PPSC_ST_RESET;      // System state
  logic [2:0]  op_mode = 3'h1, upper_address_enable = 3'h0, csu_ddr = 3'h0;
  logic        watchdog_reset = 1'b0, bus_release_enable = 1'b0;
  logic        refresh_strobe_enable = 1'b0, p61_ddr = 1'b0, p61_gpio_out = 1'b0;
  logic        p62_ddr = 1'b0, p62_gpio_out = 1'b0, bus_ack_val = 1'b0;
  logic        p80_ddr = 1'b0, p80_gpio_out = 1'b0, refresh_strobe_val = 1'b1;
  logic        cs_zero_ddr = 1'b0, chip_select_zero_val = 1'b1;
  logic [2:0]  chip_select_upper_val = 3'h2;    // Upper chip selects
  logic [3:0]  p5_ddr = 4'h0, p5_gpio_out = 4'h0, addr_hi = 4'ha, strobe_val = 4'h5;
  logic [3:0]  pa_ddr = 4'h0, pa_gpio_out = 4'h0, pa_timer_oe = 4'h0;
  logic [3:0]  pa_timer_val = 4'h0, addr_top = 4'hc;
  logic [3:0]  p5_o, p5_oe, strobe_o, strobe_oe, pa_o, pa_oe, strobe_lvl;
  logic        p61_oe, p61_o, p62_o, p62_oe, p80_o, p80_oe, cs_zero_o, cs_zero_oe;
  logic [2:0]  csu_o, csu_oe;                   // Upper chip select pins
  logic [5:0]  p7_oe;                           // Input-only port
  logic        reset_output_o, reset_output_oe; // Reset output pin
  int          mismatches = 0, n_compared = 0;  // Verdict counters

  ppsc_top i_dut (.clk, .reset_n, .sys_state, .op_mode, .watchdog_reset, .bus_release_enable,
    .refresh_strobe_enable, .upper_address_enable, .p5_ddr, .p5_gpio_out, .addr_hi,
    .strobe_val, .p61_ddr, .p61_gpio_out, .p62_ddr, .p62_gpio_out, .bus_ack_val, .p80_ddr,
    .p80_gpio_out, .refresh_strobe_val, .csu_ddr, .chip_select_upper_val, .cs_zero_ddr,
    .chip_select_zero_val, .pa_ddr, .pa_gpio_out, .pa_timer_oe, .pa_timer_val, .addr_top,
    .p5_o, .p5_oe, .strobe_o, .strobe_oe, .p61_oe, .p61_o, .p62_o, .p62_oe, .p80_o, .p80_oe,
    .csu_o, .csu_oe, .cs_zero_o, .cs_zero_oe, .pa_o, .pa_oe, .p7_oe, .reset_output_o,
    .reset_output_oe);

  // External memory watching the strobes
  ppsc_ext_bus i_mem (.clk, .strobe_o, .strobe_oe, .strobe_lvl);

  // 40 MHz system clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_compared++;
    if (got !== ex)
    begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      mismatches++;
    end
  endtask

  // Apply state and mode, then let the registered outputs land
  task automatic go(input ppsc_state_t st, input logic [2:0] md);
    sys_state = st;
    op_mode = md;
    @(negedge clk);
    @(negedge clk);
    chk("p7_oe", 8'h00, {2'b00, p7_oe});
  endtask

  // Reset state: strobes high, address low, reset output per cause
  task automatic t_reset;
    watchdog_reset = 1'b1;
    cs_zero_ddr = 1'b1;
    go(PPSC_ST_RESET, 3'h1);
    chk("p5_oe", 8'h0f, {4'h0, p5_oe});
    chk("p5_o", 8'h00, {4'h0, p5_o});
    chk("strobe_lvl", 8'h0f, {4'h0, strobe_lvl});
    chk("cs_zero", 8'h02, {6'h00, cs_zero_oe, cs_zero_o});
    chk("rst_out", 8'h02, {6'h00, reset_output_oe, reset_output_o});
    watchdog_reset = 1'b0;
    go(PPSC_ST_RESET, 3'h1);
    chk("rst_out_oe", 8'h00, {7'h00, reset_output_oe});
  endtask

  // Hardware standby floats everything
  task automatic t_hwstby;
    bus_release_enable = 1'b1;
    refresh_strobe_enable = 1'b1;
    go(PPSC_ST_HWSTBY, 3'h1);
    chk("oe_all", 8'h00, {p5_oe, strobe_oe});
    chk("bus_oe", 8'h00, {5'h00, p61_oe, p62_oe, p80_oe});
    chk("cs_oe", 8'h00, {3'h0, cs_zero_oe, csu_oe, reset_output_oe});
    chk("pa_oe", 8'h00, {4'h0, pa_oe});
  endtask

  // Software standby with release and refresh enabled
  task automatic t_swstby;
    csu_ddr = 3'h5;
    go(PPSC_ST_SWSTBY, 3'h1);
    chk("p5_oe", 8'h00, {p5_oe, strobe_oe});
    chk("p61_oe", 8'h00, {7'h00, p61_oe});
    chk("p62", 8'h03, {6'h00, p62_oe, p62_o});
    chk("p80", 8'h03, {6'h00, p80_oe, p80_o});
    chk("csu_oe", 8'h05, {5'h00, csu_oe});
    chk("csu_o", 8'h05, {5'h00, csu_o & csu_ddr});
    chk("cs_zero", 8'h02, {6'h00, cs_zero_oe, cs_zero_o});
    refresh_strobe_val = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk("p80_tgl", 8'h02, {6'h00, p80_oe, p80_o});
    cs_zero_ddr = 1'b0;
    go(PPSC_ST_SWSTBY, 3'h5);
    chk("cs_zero_oe", 8'h00, {7'h00, cs_zero_oe});
    chk("p5_oe5", 8'h00, {4'h0, p5_oe});
  endtask

  // Bus released: acknowledge low, refresh high, bus floated
  task automatic t_busrel;
    go(PPSC_ST_BUSREL, 3'h1);
    chk("p62", 8'h02, {6'h00, p62_oe, p62_o});
    chk("p80", 8'h03, {6'h00, p80_oe, p80_o});
    chk("p5_oe", 8'h00, {p5_oe, strobe_oe});
    chk("strobe_lvl", 8'h00, {4'h0, strobe_lvl});
    chk("p61_oe", 8'h00, {7'h00, p61_oe});
    chk("csu_keep", 8'h05, {5'h00, csu_oe});
  endtask

  // Execution in the expanded modes
  task automatic t_run;
    cs_zero_ddr = 1'b1;
    p5_ddr = 4'h6;
    go(PPSC_ST_RUN, 3'h1);
    chk("p5", 8'hfa, {p5_oe, p5_o});
    chk("strobe", 8'hf5, {strobe_oe, strobe_o});
    chk("p62", 8'h02, {6'h00, p62_oe, p62_o});
    chk("p80", 8'h02, {6'h00, p80_oe, p80_o});
    chk("cs_zero", 8'h03, {6'h00, cs_zero_oe, cs_zero_o});
    go(PPSC_ST_RUN, 3'h5);
    chk("p5_m5", 8'h62, {p5_oe, p5_o & p5_ddr});
    refresh_strobe_enable = 1'b0;
    bus_release_enable = 1'b0;
    p80_ddr = 1'b1;
    p62_ddr = 1'b1;
    p62_gpio_out = 1'b1;
    p61_ddr = 1'b1;
    p61_gpio_out = 1'b1;
    go(PPSC_ST_RUN, 3'h1);
    chk("p80_io", 8'h02, {6'h00, p80_oe, p80_o});
    chk("p62_io", 8'h03, {6'h00, p62_oe, p62_o});
    chk("p61_io", 8'h03, {6'h00, p61_oe, p61_o});
    pa_ddr = 4'h2;
    pa_gpio_out = 4'h3;
    go(PPSC_ST_RUN, 3'h3);
    chk("pa_addr", 8'hfc, {pa_oe, pa_o});
    upper_address_enable = 3'h7;
    go(PPSC_ST_RUN, 3'h4);
    chk("pa_io", 8'h46, {pa_oe[2:0], 1'b0, pa_o[2:0], 1'b0});
  endtask

  // Held pins keep level; port A follows direction and timer
  task automatic t_hold;
    go(PPSC_ST_SWSTBY, 3'h6);
    p62_gpio_out = 1'b0;
    p61_ddr = 1'b0;
    go(PPSC_ST_SWSTBY, 3'h6);
    chk("p62_keep", 8'h03, {6'h00, p62_oe, p62_o});
    chk("p61_keep", 8'h00, {7'h00, p61_oe});
    go(PPSC_ST_SWSTBY, 3'h3);
    chk("pa_sw", 8'h02, {4'h0, pa_oe});
    pa_timer_oe = 4'h8;
    pa_timer_val = 4'h8;
    go(PPSC_ST_BUSREL, 3'h3);
    chk("pa_rel", 8'h0a, {4'h0, pa_oe});
    chk("pa_rel_o", 8'h0b, {4'h0, pa_o});
  endtask

  // Verdict and end of run
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cut a hung run short
  initial
  begin
    repeat (2000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_hwstby();
    t_swstby();
    t_busrel();
    t_run();
    t_hold();
    stop_test();
  end
endmodule
